/* File: core/branch_sysctl_decode.sv */
// Implementation choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "branch_sysctl_cfg.svh"
module branch_sysctl_decode (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // Avalon-MM slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Core side
  output logic             sleep_mode,
  output logic             restore_req,
  output logic      [3:0]  restore_cnt
);
  import branch_sysctl_pkg::*;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  // Bus handshake: one wait state on every access
  logic resp_q;
  wire logic acc    = avs_read | avs_write;
  wire logic wr_go  = avs_write & resp_q;
  wire logic rd_cap = avs_read & ~resp_q;
  assign avs_waitrequest = acc & ~resp_q;

  logic [31:0] pc_q, pc_d, ext_q, opnd_q, vba_q, vba_d, sba_q, sba_d;
  logic [31:0] result_q, result_d, slot_q, slot_d, rdata_q;
  logic [7:0]  flg_q, flg_d, xct_q, xct_d;
  logic [3:0]  sp_q, rcnt_q, rcnt_d;
  logic        ill_q, ill_d, stk_q, stk_d, taken_q, taken_d, rreq_d, rreq_q;
  exec_state_t state_q, state_d;
  stk_entry_t  stack_q [`SP_FULL];
  logic        push, pop;
  stk_entry_t  push_val;

  // Decode of the written word
  op_class_t   op;
  logic [3:0]  sub, data_reg;
  logic [2:0]  addr_reg, bit_no, ext_bytes;
  logic [7:0]  imm8;
  logic        legal, cc_true;

  word_fields u_fields (
    .word      (avs_writedata[15:0]),
    .op        (op),
    .sub       (sub),
    .data_reg  (data_reg),
    .addr_reg  (addr_reg),
    .bit_no    (bit_no),
    .imm8      (imm8),
    .ext_bytes (ext_bytes),
    .legal     (legal)
  );

  cond_eval u_cond (
    .cc    (sub),
    .flags (flg_q),
    .taken (cc_true)
  );

  wire logic is_instr = (avs_address == `OFS_INSTR);
  wire logic exec     = wr_go & is_instr & (state_q != ST_SLEEP);
  wire logic run      = (state_q == ST_RUN);
  wire logic room     = (sp_q != `SP_FULL);
  wire logic filled   = (sp_q != `SP_EMPTY);
  wire logic [2:0] top_idx = 3'(sp_q - 4'h1);
  wire stk_entry_t top_ent = stack_q[top_idx];
  wire logic [31:0] top_pc = top_ent[31:0];

  // Fetch advances in whole words plus any extension
  wire logic [31:0] seq_pc = pc_q + `WORD_BYTES + {29'h0, ext_bytes};
  wire logic [31:0] rel16  = seq_pc + {{16{ext_q[15]}}, ext_q[15:0]};
  wire logic [31:0] rel8   = seq_pc + {{24{imm8[7]}}, imm8};
  wire logic [31:0] trap_tgt = vba_q + `TRAP_OFS + {28'h0, imm8[1:0], 2'b00};
  wire logic bit_hit = (opnd_q[bit_no] == sub[2]);
  wire logic is_call = sub[3];
  wire logic restore = sub[3];
  wire logic [7:0] logic_res =
    (sub[3:2] == 2'h0) ? ((sub[0] ? xct_q : flg_q) & imm8) :
    (sub[3:2] == 2'h1) ? ((sub[0] ? xct_q : flg_q) | imm8) :
                         ((sub[0] ? xct_q : flg_q) ^ imm8);

  wire logic st_wr   = wr_go & (avs_address == `OFS_STATUS);
  wire logic wake    = st_wr & avs_writedata[`ST_SLEEP_B] & (state_q == ST_SLEEP);
  wire logic ill_clr = st_wr & avs_writedata[`ST_ILL_B];
  wire logic stk_clr = st_wr & avs_writedata[`ST_STK_B];

  always_comb begin
    pc_d     = pc_q;
    flg_d    = flg_q;
    xct_d    = xct_q;
    vba_d    = vba_q;
    sba_d    = sba_q;
    result_d = result_q;
    slot_d   = slot_q;
    state_d  = state_q;
    taken_d  = taken_q;
    rcnt_d   = rcnt_q;
    rreq_d   = 1'b0;
    push     = 1'b0;
    pop      = 1'b0;
    push_val = {flg_q, seq_pc};
    ill_d    = ill_clr ? 1'b0 : ill_q;
    stk_d    = stk_clr ? 1'b0 : stk_q;
    if (wr_go && avs_address == `OFS_PC) pc_d = avs_writedata;
    if (wr_go && avs_address == `OFS_FLAGS) begin
      flg_d = avs_writedata[7:0];
      xct_d = avs_writedata[15:8];
    end
    if (wr_go && avs_address == `OFS_VBASE) vba_d = avs_writedata;
    if (wr_go && avs_address == `OFS_SBASE) sba_d = avs_writedata;
    if (wake) state_d = ST_RUN;
    if (exec) begin
      pc_d    = seq_pc;
      taken_d = 1'b0;
      if (!legal) ill_d = 1'b1;
      else begin
        unique case (op)
          OP_IDLE: ;
          OP_BITBR: begin
            if (bit_hit) begin
              pc_d    = rel16;
              taken_d = 1'b1;
              push    = is_call;
            end
          end
          OP_BCC: begin
            if (cc_true) begin
              pc_d    = (imm8 == 8'h00) ? rel16 : rel8;
              taken_d = 1'b1;
            end
          end
          OP_DBRA: begin
            slot_d  = rel8;
            state_d = ST_SLOT;
            taken_d = 1'b1;
          end
          OP_JUMP: begin
            pc_d    = ext_q;
            taken_d = 1'b1;
          end
          OP_CALR, OP_CALA: begin
            pc_d    = (op == OP_CALR) ? rel16 : ext_q;
            push    = 1'b1;
            taken_d = 1'b1;
          end
          OP_RTS, OP_ERET: begin
            if (filled) begin
              pop     = 1'b1;
              pc_d    = top_pc;
              taken_d = 1'b1;
              if (op == OP_ERET) flg_d = top_ent[39:32];
              rreq_d  = restore;
              if (restore) rcnt_d = data_reg;
            end else stk_d = 1'b1;
          end
          OP_TRAP: begin
            pc_d    = trap_tgt;
            push    = 1'b1;
            taken_d = 1'b1;
          end
          OP_SLEEP: state_d = ST_SLEEP;
          OP_CLOAD: begin
            unique case (sub[2:0])
              3'h0: flg_d = imm8;
              3'h1: xct_d = imm8;
              3'h2: flg_d = opnd_q[7:0];
              3'h3: xct_d = opnd_q[7:0];
              3'h4: flg_d = opnd_q[15:8];
              3'h5: xct_d = opnd_q[15:8];
              3'h6: vba_d = opnd_q;
              3'h7: sba_d = opnd_q;
            endcase
          end
          OP_CSTORE: begin
            unique case (sub[2:0])
              3'h0: result_d = {24'h0, flg_q};
              3'h1: result_d = {24'h0, xct_q};
              3'h2: result_d = {16'h0, flg_q, 8'h00};
              3'h3: result_d = {16'h0, xct_q, 8'h00};
              3'h4: result_d = vba_q;
              3'h5: result_d = sba_q;
              default: ;
            endcase
          end
          OP_LOGC: begin
            if (sub[0]) xct_d = logic_res;
            else flg_d = logic_res;
          end
          default: ill_d = 1'b1;
        endcase
      end
      if (push && !room) stk_d = 1'b1;
      // The slot word runs first, then control moves to the held target
      if (state_q == ST_SLOT) begin
        pc_d    = slot_q;
        state_d = (state_d == ST_SLEEP) ? ST_SLEEP : ST_RUN;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      resp_q   <= 1'b0;
      pc_q     <= `RST_PC;
      ext_q    <= 32'h0000_0000;
      opnd_q   <= 32'h0000_0000;
      vba_q    <= `RST_BASE;
      sba_q    <= `RST_BASE;
      result_q <= 32'h0000_0000;
      slot_q   <= `RST_PC;
      flg_q    <= `RST_CTL;
      xct_q    <= `RST_CTL;
      state_q  <= ST_RUN;
      taken_q  <= 1'b0;
      ill_q    <= 1'b0;
      stk_q    <= 1'b0;
      rreq_q   <= 1'b0;
      rcnt_q   <= 4'h0;
    end else begin
      resp_q   <= acc & ~resp_q;
      pc_q     <= pc_d;
      vba_q    <= vba_d;
      sba_q    <= sba_d;
      result_q <= result_d;
      slot_q   <= slot_d;
      flg_q    <= flg_d;
      xct_q    <= xct_d;
      state_q  <= state_d;
      taken_q  <= taken_d;
      ill_q    <= ill_d;
      stk_q    <= stk_d;
      rreq_q   <= rreq_d;
      rcnt_q   <= rcnt_d;
      if (wr_go && avs_address == `OFS_EXT) ext_q <= avs_writedata;
      if (wr_go && avs_address == `OFS_OPND) opnd_q <= avs_writedata;
    end
  end

  // Return stack; an overflowing push is dropped and flagged
  always_ff @(posedge sys_clk) begin
    if (reset) sp_q <= `SP_EMPTY;
    else if (push && room) sp_q <= sp_q + 4'h1;
    else if (pop) sp_q <= sp_q - 4'h1;
  end

  always_ff @(posedge sys_clk) begin
    if (push && room) stack_q[sp_q[2:0]] <= push_val;
  end

  wire logic [31:0] status_w = {20'h0, sp_q, 3'h0, taken_q, stk_q, ill_q,
                                state_q == ST_SLOT, state_q == ST_SLEEP};
  wire logic [31:0] rd_mux =
    (avs_address == `OFS_EXT)    ? ext_q :
    (avs_address == `OFS_OPND)   ? opnd_q :
    (avs_address == `OFS_PC)     ? pc_q :
    (avs_address == `OFS_FLAGS)  ? {16'h0, xct_q, flg_q} :
    (avs_address == `OFS_VBASE)  ? vba_q :
    (avs_address == `OFS_SBASE)  ? sba_q :
    (avs_address == `OFS_RESULT) ? result_q :
    (avs_address == `OFS_STATUS) ? status_w :
    (avs_address == `OFS_RETTOP) ? (filled ? top_pc : 32'h0) : 32'h0000_0000;

  always_ff @(posedge sys_clk) begin
    if (reset) rdata_q <= 32'h0000_0000;
    else if (rd_cap) rdata_q <= rd_mux;
  end

  assign avs_readdata = rdata_q;
  assign sleep_mode   = (state_q == ST_SLEEP);
  assign restore_req  = rreq_q;
  assign restore_cnt  = rcnt_q;

  sequence s_run_exec(op_class_t o);
    exec && run && legal && op == o;
  endsequence

  chk_bit_miss: assert property (
    s_run_exec(OP_BITBR) and (exec && !bit_hit) |=> pc_q == $past(seq_pc))
    else $error("bit branch moved on a miss");
  chk_bit_call: assert property (
    s_run_exec(OP_BITBR) and (exec && bit_hit && is_call && room)
    |=> sp_q == $past(sp_q) + 4'h1 && pc_q == $past(rel16) && top_pc == $past(seq_pc))
    else $error("bit call did not save return");
  chk_cond_false: assert property (
    s_run_exec(OP_BCC) and (exec && !cc_true) |=> pc_q == $past(seq_pc))
    else $error("false condition branched");
  chk_delay_slot: assert property (
    s_run_exec(OP_DBRA) |=> state_q == ST_SLOT && pc_q == $past(seq_pc))
    else $error("delayed branch skipped slot");
  chk_slot_target: assert property (
    exec && state_q == ST_SLOT |=> pc_q == $past(slot_q) && state_q != ST_SLOT)
    else $error("slot did not reach target");
  chk_jump_abs: assert property (
    s_run_exec(OP_JUMP) |=> pc_q == $past(ext_q) && $stable(sp_q))
    else $error("jump wrong target or push");
  chk_call_push: assert property (
    s_run_exec(OP_CALA) and (exec && room) |=> top_pc == $past(seq_pc) && pc_q == $past(ext_q))
    else $error("call lost return point");
  chk_return_pc: assert property (
    s_run_exec(OP_RTS) and (exec && filled) |=> pc_q == $past(top_pc) && sp_q == $past(sp_q) - 4'h1)
    else $error("return wrong point");
  chk_trap_entry: assert property (
    s_run_exec(OP_TRAP) |=> pc_q == $past(trap_tgt))
    else $error("trap wrong vector");
  chk_sleep_entry: assert property (
    s_run_exec(OP_SLEEP) |=> sleep_mode)
    else $error("sleep not entered");
  chk_logic_and: assert property (
    s_run_exec(OP_LOGC) and (exec && sub[3:0] == 4'h0) |=> flg_q == ($past(flg_q) & $past(imm8)))
    else $error("and immediate wrong");
  chk_nop_only: assert property (
    s_run_exec(OP_IDLE) |=> pc_q == $past(pc_q) + `WORD_BYTES && $stable(flg_q) && $stable(sp_q))
    else $error("no-operation changed state");
endmodule // branch_sysctl_decode
`default_nettype wire

/* File: core/branch_sysctl_cfg.svh */
`ifndef BRANCH_SYSCTL_CFG_SVH
`define BRANCH_SYSCTL_CFG_SVH
`define OFS_INSTR   6'h00
`define OFS_EXT     6'h04
`define OFS_OPND    6'h08
`define OFS_PC      6'h0C
`define OFS_FLAGS   6'h10
`define OFS_VBASE   6'h14
`define OFS_SBASE   6'h18
`define OFS_RESULT  6'h1C
`define OFS_STATUS  6'h20
`define OFS_RETTOP  6'h24
`define FLG_C       0
`define FLG_V       1
`define FLG_Z       2
`define FLG_N       3
`define ST_SLEEP_B  0
`define ST_ILL_B    2
`define ST_STK_B    3
`define WORD_BYTES  32'h0000_0002
`define EXT_NONE    3'h0
`define EXT_16      3'h2
`define EXT_32      3'h4
`define SP_EMPTY    4'h0
`define SP_FULL     4'h8
`define RST_PC      32'h0000_0000
`define RST_BASE    32'h0000_0000
`define RST_CTL     8'h00
`define TRAP_OFS    32'h0000_0020
`endif

/* File: core/branch_sysctl_pkg.sv */
package branch_sysctl_pkg;
  typedef enum logic [3:0] {
    OP_IDLE = 4'h0, OP_BITBR = 4'h1, OP_BCC = 4'h2, OP_DBRA = 4'h3,
    OP_JUMP = 4'h4, OP_CALR = 4'h5, OP_CALA = 4'h6, OP_RTS = 4'h7,
    OP_TRAP = 4'h8, OP_ERET = 4'h9, OP_SLEEP = 4'hA, OP_CLOAD = 4'hB,
    OP_CSTORE = 4'hC, OP_LOGC = 4'hD
  } op_class_t;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00, ST_SLOT = 2'b01, ST_SLEEP = 2'b10
  } exec_state_t;
  typedef logic [39:0] stk_entry_t;
endpackage

/* File: core/word_fields.sv */
`timescale 1ns/1ps
`default_nettype none
`include "branch_sysctl_cfg.svh"
module word_fields (
  // Instruction word
  input  wire logic                          [15:0] word,
  // Fields
  output var branch_sysctl_pkg::op_class_t          op,
  output logic                               [3:0]  sub,
  output logic                               [3:0]  data_reg,
  output logic                               [2:0]  addr_reg,
  output logic                               [2:0]  bit_no,
  output logic                               [7:0]  imm8,
  output logic                               [2:0]  ext_bytes,
  output logic                                      legal
);
  import branch_sysctl_pkg::*;

  assign op       = op_class_t'(word[15:12]);
  assign sub      = word[11:8];
  assign data_reg = word[7:4];
  assign addr_reg = word[6:4];
  assign bit_no   = word[2:0];
  assign imm8     = word[7:0];

  // Extension length following the leading word
  always_comb begin
    ext_bytes = `EXT_NONE;
    legal     = 1'b1;
    unique case (word[15:12])
      OP_BITBR, OP_CALR: ext_bytes = `EXT_16;
      OP_BCC:   ext_bytes = (word[7:0] == 8'h00) ? `EXT_16 : `EXT_NONE;
      OP_JUMP, OP_CALA: ext_bytes = `EXT_32;
      OP_CLOAD: begin
        ext_bytes = (word[11:9] == 3'h2) ? `EXT_16 : `EXT_NONE;
        legal     = ~word[11];
      end
      OP_CSTORE: begin
        ext_bytes = (word[11:9] == 3'h1) ? `EXT_16 : `EXT_NONE;
        legal     = (word[11:8] < 4'h6);
      end
      OP_LOGC:  legal = (word[11:10] != 2'h3);
      OP_IDLE, OP_DBRA, OP_RTS, OP_TRAP, OP_ERET, OP_SLEEP: ext_bytes = `EXT_NONE;
      default:  legal = 1'b0;
    endcase
  end
endmodule // word_fields
`default_nettype wire

/* File: core/cond_eval.sv */
`timescale 1ns/1ps
`default_nettype none
`include "branch_sysctl_cfg.svh"
module cond_eval (
  // Condition field and flags
  input  wire logic [3:0] cc,
  input  wire logic [7:0] flags,
  // Verdict
  output logic            taken
);
  wire logic c = flags[`FLG_C];
  wire logic v = flags[`FLG_V];
  wire logic z = flags[`FLG_Z];
  wire logic n = flags[`FLG_N];

  always_comb begin
    unique case (cc)
      4'h0: taken = 1'b1;
      4'h1: taken = 1'b0;
      4'h2: taken = ~(c | z);
      4'h3: taken = c | z;
      4'h4: taken = ~c;
      4'h5: taken = c;
      4'h6: taken = ~z;
      4'h7: taken = z;
      4'h8: taken = ~v;
      4'h9: taken = v;
      4'hA: taken = ~n;
      4'hB: taken = n;
      4'hC: taken = ~(n ^ v);
      4'hD: taken = n ^ v;
      4'hE: taken = ~z & ~(n ^ v);
      4'hF: taken = z | (n ^ v);
    endcase
  end
endmodule // cond_eval
`default_nettype wire

/* File: tb/prog_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model (
  // Clock
  input  wire logic        sys_clk,
  // Loader port
  input  wire logic        load_en,
  input  wire logic [31:0] load_addr,
  input  wire logic [15:0] load_word,
  // Fetch port
  input  wire logic [31:0] fetch_addr,
  output logic      [15:0] fetch_word
);
  logic [15:0] mem_q [0:255];

  // Whole 16-bit words only, so address bit 0 never picks a byte
  always_ff @(posedge sys_clk) begin
    if (load_en) begin
      mem_q[load_addr[8:1]] <= load_word;
    end
  end

  // An odd fetch returns an illegal opcode, so a misaligned program counter shows up
  assign fetch_word = fetch_addr[0] ? 16'hFFFF : mem_q[fetch_addr[8:1]];
endmodule // prog_mem_model
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "branch_sysctl_cfg.svh"
module tb_top;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        sleep_mode;
  logic        restore_req;
  logic [3:0]  restore_cnt;
  logic        load_en = 1'b0;
  logic [31:0] load_addr = 32'h0;
  logic [15:0] load_word = 16'h0;
  logic [15:0] fetch_word;
  logic [31:0] rd, m_pc, m_vb, m_sb, m_ext, m_opnd, m_res, m_dtgt;
  logic [7:0]  m_flg, m_xct;
  logic        m_dly;
  logic [39:0] m_stk[$];
  int          error_cnt = 0;
  int          checks_done = 0;
  int          pulses = 0;

  always #50 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    if (restore_req === 1'b1) pulses <= pulses + 1;
  end

  branch_sysctl_decode branch_sysctl_decode_inst (.sys_clk, .reset, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .sleep_mode, .restore_req,
    .restore_cnt);
  prog_mem_model prog_mem_model_inst (.sys_clk, .load_en, .load_addr, .load_word,
    .fetch_addr(m_pc), .fetch_word);

  task automatic end_of_test();
    $display("errors %0d, checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Holds the request until waitrequest is seen low, then lets one edge pass
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) begin
      n++;
      if (n > 20) begin
        error_cnt++;
        $display("CHECK FAILED at %0t: bus never answered", $time);
        end_of_test();
      end
      @(posedge sys_clk);
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rdc(input logic [5:0] a, input logic [31:0] exp, input logic [31:0] mask);
    bus(1'b0, a, 32'h0);
    check(rd & mask, exp, "register read");
  endtask

  task automatic setx(input logic [31:0] x, input logic [31:0] o);
    m_ext = x;
    m_opnd = o;
    bus(1'b1, `OFS_EXT, x);
    bus(1'b1, `OFS_OPND, o);
  endtask

  task automatic setf(input logic [15:0] f);
    {m_xct, m_flg} = f;
    bus(1'b1, `OFS_FLAGS, {16'h0, f});
  endtask

  task automatic load(input logic [31:0] a, input logic [15:0] w);
    load_addr <= a;
    load_word <= w;
    load_en <= 1'b1;
    @(posedge sys_clk);
  endtask

  function automatic logic cond(input logic [3:0] cc);
    logic c, v, z, n, r;
    {n, z, v, c} = m_flg[3:0];
    case (cc[3:1])
      3'h0: r = 1'b1;
      3'h1: r = ~(c | z);
      3'h2: r = ~c;
      3'h3: r = ~z;
      3'h4: r = ~v;
      3'h5: r = ~n;
      3'h6: r = n == v;
      default: r = ~z & (n == v);
    endcase
    return cc[0] ? ~r : r;
  endfunction

  function automatic void step(input logic [15:0] w);
    logic [3:0]  sub;
    logic [31:0] seq, nx;
    logic [39:0] e;
    logic [7:0]  v;
    sub = w[11:8];
    seq = m_pc + 32'h2;
    nx = seq;
    case (w[15:12])
      4'h1: begin
        seq = m_pc + 32'h4;
        nx = seq;
        if (m_opnd[w[2:0]] == sub[2]) begin
          nx = seq + {{16{m_ext[15]}}, m_ext[15:0]};
          if (sub[3]) m_stk.push_back({m_flg, seq});
        end
      end
      4'h2: if (cond(sub)) nx = seq + {{24{w[7]}}, w[7:0]};
      4'h3: m_dtgt = seq + {{24{w[7]}}, w[7:0]};
      4'h4: nx = m_ext;
      4'h5: begin
        m_stk.push_back({m_flg, m_pc + 32'h4});
        nx = m_pc + 32'h4 + {{16{m_ext[15]}}, m_ext[15:0]};
      end
      4'h6: begin
        m_stk.push_back({m_flg, m_pc + 32'h6});
        nx = m_ext;
      end
      4'h7, 4'h9: begin
        e = m_stk.pop_back();
        nx = e[31:0];
        // Only the exception return brings the saved flags back
        if (w[15:12] == 4'h9) m_flg = e[39:32];
      end
      4'h8: begin
        m_stk.push_back({m_flg, seq});
        nx = m_vb + `TRAP_OFS + {28'h0, w[1:0], 2'b00};
      end
      4'hB: begin
        v = sub[2] ? m_opnd[15:8] : (sub[1] ? m_opnd[7:0] : w[7:0]);
        if (sub[2:1] == 2'b11) begin
          if (sub[0]) m_sb = m_opnd;
          else m_vb = m_opnd;
        end else if (sub[0]) m_xct = v;
        else m_flg = v;
        if (sub[2:1] == 2'b10) nx = m_pc + 32'h4;
      end
      4'hC: begin
        v = sub[0] ? m_xct : m_flg;
        m_res = sub[2] ? (sub[0] ? m_sb : m_vb) : (sub[1] ? {16'h0, v, 8'h0} : {24'h0, v});
        if (sub[2:1] == 2'b01) nx = m_pc + 32'h4;
      end
      4'hD: begin
        v = sub[0] ? m_xct : m_flg;
        v = sub[3] ? v ^ w[7:0] : (sub[2] ? v | w[7:0] : v & w[7:0]);
        if (sub[0]) m_xct = v;
        else m_flg = v;
      end
      default: ;
    endcase
    if (m_dly) nx = m_dtgt;
    m_dly = w[15:12] == 4'h3;
    m_pc = nx;
  endfunction

  task automatic run(input logic [15:0] w);
    step(w);
    bus(1'b1, `OFS_INSTR, {16'h0, w});
    rdc(`OFS_PC, m_pc, 32'hFFFF_FFFF);
    rdc(`OFS_FLAGS, {16'h0, m_xct, m_flg}, 32'hFFFF_FFFF);
    rdc(`OFS_RETTOP, m_stk.size() ? m_stk[$][31:0] : 32'h0, 32'hFFFF_FFFF);
    rdc(`OFS_STATUS, {20'h0, 4'(m_stk.size()), 8'h00}, 32'h0000_0F00);
  endtask

  initial begin
    repeat (90000) @(posedge sys_clk);
    error_cnt++;
    $display("CHECK FAILED at %0t: run limit reached", $time);
    end_of_test();
  end

  initial begin
    void'($urandom(55));
    {m_pc, m_vb, m_sb, m_ext, m_opnd, m_res, m_dtgt} = '0;
    {m_flg, m_xct, m_dly} = '0;
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    for (int i = 0; i < 10; i++) rdc(6'(i * 4), 32'h0, 32'hFFFF_FFFF);
    rdc(6'h3C, 32'h0, 32'hFFFF_FFFF);
    run(16'h0000);
    for (int i = 0; i < 32; i++) begin
      setf({12'h000, 4'($urandom)});
      run({4'h2, 4'(i), 7'($urandom_range(1, 127)), 1'b0});
    end
    for (int i = 0; i < 8; i++) begin
      setx({16'h0, 15'($urandom), 1'b0}, $urandom);
      run({4'h1, i[1:0], 2'b00, 5'h00, 3'($urandom)});
    end
    while (m_stk.size() > 0) run(16'h7000);
    setx({$urandom} & 32'hFFFF_FFFE, 32'h0);
    run(16'h4000);
    run(16'h6000);
    setx({16'h0, 15'($urandom), 1'b0}, 32'h0);
    run(16'h5000);
    run(16'h7A30);
    check({28'h0, restore_cnt}, 32'h3, "restore count");
    check(pulses, 1, "restore pulses");
    run(16'h7000);
    for (int i = 0; i < 2; i++) begin
      setx(32'h0, {$urandom} & 32'hFFFF_FF00);
      run({4'hB, 4'(6 + i), 8'h00});
      run({4'hC, 4'(4 + i), 8'h00});
      rdc(`OFS_RESULT, m_res, 32'hFFFF_FFFF);
    end
    for (int i = 0; i < 6; i++) begin
      setx(32'h0, $urandom);
      run({4'hB, 4'(i), 8'($urandom)});
      run({4'hC, 4'(i & 3), 8'h00});
      rdc(`OFS_RESULT, m_res, 32'hFFFF_FFFF);
    end
    for (int i = 0; i < 6; i++) run({4'hD, 4'(i / 2 * 4 + i % 2), 8'($urandom)});
    setf(16'($urandom));
    run(16'h8002);
    run(16'hD000);
    run(16'h9000);
    setx(32'h0000_0100, 32'h0);
    run(16'h4000);
    load(32'h100, 16'h3008);
    load(32'h102, 16'hD4F0);
    load_en <= 1'b0;
    @(posedge sys_clk);
    repeat (2) run(fetch_word);
    run(16'hA000);
    check({31'h0, sleep_mode}, 32'h1, "asleep");
    bus(1'b1, `OFS_INSTR, 32'h0);
    rdc(`OFS_PC, m_pc, 32'hFFFF_FFFF);
    bus(1'b1, `OFS_STATUS, 32'h1);
    check({31'h0, sleep_mode}, 32'h0, "awake");
    run(16'hE000);
    rdc(`OFS_STATUS, 32'h4, 32'h4);
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
